// file: ifc_inband_flow.sv
`timescale 1ns/10ps
module ifc_inband_flow (
   input  wire logic       clk_sys,                 // system clock
   input  wire logic       rst,                     // asynchronous reset, active high
   // character programming
   input  wire logic       resume_char_wr,          // write resume code
   input  wire logic       stop_char_wr,            // write stop code
   input  wire logic [7:0] char_wr_data,            // code value written
   // option bits
   input  wire logic       special_char_detect_en,  // compare received characters
   input  wire logic       tx_auto_inband_en,       // automatic transmit flow control
   input  wire logic       implied_resume_en,       // any character but the stop code restarts
   input  wire logic       flow_transparency_en,    // discard received flow codes
   input  wire logic       match_on_error_en,       // errored characters may match
   // host commands, one-cycle pulses
   input  wire logic       cmd_send_resume,         // send resume code
   input  wire logic       cmd_send_stop,           // send stop code
   input  wire logic       cmd_rx_enable_change,    // receiver enabled or disabled
   input  wire logic       cmd_tx_enable_change,    // transmitter enabled or disabled
   // prescaler
   input  wire logic       prescaler_tick,          // delay timer tick
   // transmit queue head
   input  wire logic       txq_valid,               // queue holds a character
   input  wire logic       txq_is_delay,            // head is a delay command
   input  wire logic [7:0] txq_data,                // head character or delay parameter
   // transmit engine
   input  wire logic       tx_take,                 // holding stage free, wants a character
   // received characters
   input  wire logic       rx_valid,                // character received
   input  wire logic [7:0] rx_data,                 // received character
   input  wire logic       rx_error,                // character had an error
   // outputs
   output logic            txq_pop,                 // remove queue head
   output logic            tx_load_valid,           // character for holding stage
   output logic      [7:0] tx_load_data,            // that character
   output logic            tx_delay_active,         // delay in progress
   output logic            rx_push_valid,           // byte for receive fifo
   output logic      [7:0] rx_push_data,            // that byte
   output logic            rx_push_is_status,       // byte is exception status
   output logic            rx_exception_req,        // exception service request pulse
   output logic      [7:0] resume_char_reg,         // programmed resume code
   output logic      [7:0] stop_char_reg,           // programmed stop code
   output logic            rx_stop_sent_flag,       // stop code sent to remote
   output logic            rx_resume_sent_flag,     // resume code sent to remote
   output logic            tx_stopped_flag,         // halted by received stop code
   output logic            tx_resume_seen_flag      // resume received, not yet restarted
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic       send_resume_pend_reg;   // resume code waiting for holding stage
   logic       send_stop_pend_reg;     // stop code waiting for holding stage
   logic       resume_out_reg;         // resume code has left for the line
   logic [7:0] timer_count;            // delay timer count
   logic       delay_load;             // start a delay this cycle
   logic       rx_match_ok;            // comparison allowed for this character
   logic       rx_is_stop;             // received stop code
   logic       rx_is_resume;           // received resume code
   logic       rx_restart;             // received character restarts transmitter
   logic       tx_halted;              // remote flow halt in force
   logic       fifo_load;              // queue character goes to holding stage
   logic       special_load;           // special character goes to holding stage
   ifc_pkg::ifc_push_type push_state_reg;  // push sequencer
   logic [7:0] push_char_reg;          // character kept for second byte
   logic       next_is_delay;          // another delay waits at the queue head

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // true while the delay timer holds no count
   function automatic logic timer_idle(input logic [7:0] cnt);
      timer_idle = (cnt == ifc_pkg::IFC_ZERO_CHAR);
   endfunction : timer_idle

   // -----------------------------------------------------------------
   // receive comparison
   // -----------------------------------------------------------------
   assign rx_match_ok  = rx_valid && special_char_detect_en && tx_auto_inband_en
                         && (!rx_error || match_on_error_en);
   // stop code wins when both codes are equal
   assign rx_is_stop   = rx_match_ok && (rx_data == stop_char_reg);
   assign rx_is_resume = rx_match_ok && (rx_data == resume_char_reg) && !rx_is_stop;
   // implied resume lets any character other than the stop code restart a stopped transmitter
   assign rx_restart   = rx_is_resume || (rx_valid && tx_auto_inband_en && implied_resume_en
                         && tx_stopped_flag && !rx_is_stop);

   // -----------------------------------------------------------------
   // transmit arbitration
   // -----------------------------------------------------------------
   // halt gates queue data only, special sends pass regardless
   assign tx_halted    = tx_stopped_flag;
   assign special_load = tx_take && (send_resume_pend_reg || send_stop_pend_reg);
   assign next_is_delay = txq_valid && txq_is_delay && !txq_pop && !tx_halted;
   // a delay head loads only while the timer is idle
   assign delay_load   = next_is_delay && timer_idle(timer_count);
   assign fifo_load    = tx_take && !special_load && txq_valid && !txq_is_delay && !txq_pop
                         && !tx_halted && timer_idle(timer_count);

   // -----------------------------------------------------------------
   // delay timer
   // -----------------------------------------------------------------
   // arbitration above watches the count for zero
   ifc_delay_timer i_ifc_delay_timer (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .load       (delay_load),
      .load_value (txq_data),
      .tick       (prescaler_tick),
      .count      (timer_count)
   );

   // delay flag shows a running count
   // a delay queued behind keeps the flag up across the reload
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_delay_active <= 1'b0;
      end else begin
         tx_delay_active <= delay_load || (timer_count > 8'h01)
                            || ((timer_count == 8'h01) && (!prescaler_tick || next_is_delay));
      end
   end

   // -----------------------------------------------------------------
   // flow code registers
   // -----------------------------------------------------------------
   // host writes either code at any time
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         resume_char_reg <= ifc_pkg::IFC_RESUME_RST;
         stop_char_reg   <= ifc_pkg::IFC_STOP_RST;
      end else begin
         if (resume_char_wr) begin
            resume_char_reg <= char_wr_data;
         end
         if (stop_char_wr) begin
            stop_char_reg <= char_wr_data;
         end
      end
   end

   // -----------------------------------------------------------------
   // pending special sends
   // -----------------------------------------------------------------
   // a new command in the cycle the old one leaves stays pending
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         send_resume_pend_reg <= 1'b0;
         send_stop_pend_reg   <= 1'b0;
      end else begin
         if (cmd_send_resume) begin
            send_resume_pend_reg <= 1'b1;
         end else if (special_load && send_resume_pend_reg) begin
            send_resume_pend_reg <= 1'b0;
         end
         if (cmd_send_stop) begin
            send_stop_pend_reg <= 1'b1;
         end else if (special_load && !send_resume_pend_reg) begin
            send_stop_pend_reg <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // holding stage load and queue pop
   // -----------------------------------------------------------------
   // one character per take, special sends first
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_load_valid <= 1'b0;
         tx_load_data  <= ifc_pkg::IFC_ZERO_CHAR;
         txq_pop       <= 1'b0;
      end else begin
         tx_load_valid <= special_load || fifo_load;
         txq_pop       <= fifo_load || delay_load;
         if (special_load) begin
            // resume goes ahead of stop when both wait
            tx_load_data <= send_resume_pend_reg ? resume_char_reg : stop_char_reg;
         end else if (fifo_load) begin
            tx_load_data <= txq_data;
         end
      end
   end

   // -----------------------------------------------------------------
   // receive-side flow flags
   // -----------------------------------------------------------------
   // commands win over an enable change in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_stop_sent_flag   <= 1'b0;
         rx_resume_sent_flag <= 1'b0;
         resume_out_reg      <= 1'b0;
      end else begin
         if (cmd_send_resume) begin
            rx_stop_sent_flag   <= 1'b0;
            rx_resume_sent_flag <= 1'b1;
            resume_out_reg      <= 1'b0;
         end else if (cmd_send_stop) begin
            rx_stop_sent_flag   <= 1'b1;
            rx_resume_sent_flag <= 1'b0;
         end else if (cmd_rx_enable_change) begin
            rx_stop_sent_flag   <= 1'b0;
            rx_resume_sent_flag <= 1'b0;
            resume_out_reg      <= 1'b0;
         end else begin
            if (special_load && send_resume_pend_reg) begin
               resume_out_reg <= 1'b1;
            end
            if (rx_valid && resume_out_reg) begin
               rx_resume_sent_flag <= 1'b0;
               resume_out_reg      <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // transmit-side flow flags
   // -----------------------------------------------------------------
   // received codes win over an enable change in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_stopped_flag     <= 1'b0;
         tx_resume_seen_flag <= 1'b0;
      end else if (rx_is_stop) begin
         tx_stopped_flag     <= 1'b1;
         tx_resume_seen_flag <= 1'b0;
      end else if (rx_restart) begin
         tx_stopped_flag     <= 1'b0;
         tx_resume_seen_flag <= 1'b1;
      end else if (cmd_tx_enable_change) begin
         tx_stopped_flag     <= 1'b0;
         tx_resume_seen_flag <= 1'b0;
      // the first queue load is the actual restart
      end else if (fifo_load) begin
         tx_stopped_flag     <= 1'b0;
         tx_resume_seen_flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // receive fifo push sequencer
   // -----------------------------------------------------------------
   // characters are accepted whatever the stop-sent flag says, except those arriving while a status pair is pushed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         push_state_reg    <= ifc_pkg::IFC_PUSH_IDLE;
         push_char_reg     <= ifc_pkg::IFC_ZERO_CHAR;
         rx_push_valid     <= 1'b0;
         rx_push_data      <= ifc_pkg::IFC_ZERO_CHAR;
         rx_push_is_status <= 1'b0;
         rx_exception_req  <= 1'b0;
      end else begin
         rx_exception_req <= 1'b0;
         unique case (push_state_reg)
            ifc_pkg::IFC_PUSH_IDLE: begin
               if (rx_valid && (rx_is_stop || rx_is_resume) && !flow_transparency_en) begin
                  // flow code given to host as an exception
                  push_state_reg    <= ifc_pkg::IFC_PUSH_STATUS;
                  push_char_reg     <= rx_data;
                  rx_push_valid     <= 1'b1;
                  rx_push_is_status <= 1'b1;
                  rx_push_data      <= (rx_is_stop ? ifc_pkg::IFC_STAT_STOP
                                                   : ifc_pkg::IFC_STAT_RESUME)
                                       | (rx_error ? ifc_pkg::IFC_STAT_ERRBIT
                                                   : ifc_pkg::IFC_ZERO_CHAR);
                  rx_exception_req  <= 1'b1;
               end else if (rx_valid && !(rx_is_stop || rx_is_resume)) begin
                  // ordinary character passes straight on
                  rx_push_valid     <= 1'b1;
                  rx_push_is_status <= 1'b0;
                  rx_push_data      <= rx_data;
               end else begin
                  // idle, or flow code discarded under transparency
                  rx_push_valid     <= 1'b0;
                  rx_push_is_status <= 1'b0;
               end
            end
            ifc_pkg::IFC_PUSH_STATUS: begin
               // second byte carries the character itself
               push_state_reg    <= ifc_pkg::IFC_PUSH_CHAR;
               rx_push_valid     <= 1'b1;
               rx_push_is_status <= 1'b0;
               rx_push_data      <= push_char_reg;
            end
            ifc_pkg::IFC_PUSH_CHAR: begin
               // a character arriving now is lost; the line spaces them out
               push_state_reg    <= ifc_pkg::IFC_PUSH_IDLE;
               rx_push_valid     <= 1'b0;
               rx_push_is_status <= 1'b0;
            end
            default: begin
               push_state_reg    <= ifc_pkg::IFC_PUSH_IDLE;
               rx_push_valid     <= 1'b0;
               rx_push_is_status <= 1'b0;
            end
         endcase
      end
   end

endmodule : ifc_inband_flow

// file: ifc_pkg.sv
package ifc_pkg;

   // -----------------------------------------------------------------
   // widths and reset values
   // -----------------------------------------------------------------
   localparam int          IFC_CHAR_W      = 8;      // character width
   localparam logic [7:0]  IFC_RESUME_RST  = 8'h11;  // resume code after reset
   localparam logic [7:0]  IFC_STOP_RST    = 8'h13;  // stop code after reset
   localparam logic [7:0]  IFC_ZERO_CHAR   = 8'h00;  // cleared character value

   // -----------------------------------------------------------------
   // exception status bytes pushed ahead of a flow character
   // -----------------------------------------------------------------
   localparam logic [7:0]  IFC_STAT_STOP   = 8'h01;  // stop code received
   localparam logic [7:0]  IFC_STAT_RESUME = 8'h02;  // resume code received
   localparam logic [7:0]  IFC_STAT_ERRBIT = 8'h80;  // or'd in when char had an error

   // -----------------------------------------------------------------
   // receive push sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      IFC_PUSH_IDLE   = 2'b00,  // nothing to push
      IFC_PUSH_STATUS = 2'b01,  // status byte on the push port
      IFC_PUSH_CHAR   = 2'b11   // character byte on the push port
   } ifc_push_type;

endpackage : ifc_pkg

// file: ifc_delay_timer.sv
`timescale 1ns/10ps
module ifc_delay_timer (
   input  wire logic       clk_sys,     // system clock
   input  wire logic       rst,         // asynchronous reset, active high
   input  wire logic       load,        // load count this cycle
   input  wire logic [7:0] load_value,  // parameter byte of delay command
   input  wire logic       tick,        // prescaler tick
   output logic      [7:0] count        // current count, zero when idle
);

   // -----------------------------------------------------------------
   // countdown
   // -----------------------------------------------------------------
   // load wins over a tick in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= ifc_pkg::IFC_ZERO_CHAR;
      end else if (load) begin
         count <= load_value;
      end else if (tick && (count != ifc_pkg::IFC_ZERO_CHAR)) begin
         count <= count - 8'h01;
      end
   end

endmodule : ifc_delay_timer

// file: ifc_remote_model.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// far side: transmit engine taking characters, remote line sending them
// -----------------------------------------------------------------
module ifc_remote_model (
   input  wire logic       clk_sys,    // system clock
   input  wire logic       rst,        // reset, active high
   input  wire logic       take_en,    // engine asks for characters
   input  wire logic       send_req,   // bench asks for one received character
   input  wire logic [7:0] send_char,  // that character
   input  wire logic       send_err,   // deliver it flagged as errored
   output logic            tx_take,    // holding stage free
   output logic            rx_valid,   // character arrives
   output logic      [7:0] rx_data,    // arriving character
   output logic            rx_error    // arriving character errored
);
   logic [1:0] gap_cnt = 2'h0;                     // keeps take pulses three cycles apart
   logic       req_s, err_s, en_s;                 // inputs sampled at the edge
   logic [7:0] chr_s;                              // character sampled at the edge
   initial {tx_take, rx_valid, rx_data, rx_error} = 11'h000;
   // sample on the edge, drive a little after it
   always @(posedge clk_sys) begin
      {req_s, chr_s, err_s, en_s} = {send_req, send_char, send_err, take_en && !rst};
      #1;
      tx_take  <= en_s && gap_cnt == 2'h0;
      gap_cnt  <= (gap_cnt == 2'h2) ? 2'h0 : gap_cnt + 2'h1;
      rx_valid <= req_s;
      rx_data  <= req_s ? chr_s : ~rx_data;        // idle line never repeats the last char
      rx_error <= req_s ? err_s : ~rx_error;
   end
endmodule : ifc_remote_model

// file: ifc_inband_flow_monitor.sv
`timescale 1ns/10ps
module ifc_inband_flow_monitor (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       cmd_send_resume,
   input wire logic       cmd_send_stop,
   input wire logic       cmd_tx_enable_change,
   input wire logic       special_char_detect_en,
   input wire logic       tx_auto_inband_en,
   input wire logic       match_on_error_en,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_error,
   input wire logic [7:0] resume_char_reg,
   input wire logic [7:0] stop_char_reg,
   input wire logic       rx_stop_sent_flag,
   input wire logic       rx_resume_sent_flag,
   input wire logic       tx_stopped_flag,
   input wire logic       tx_resume_seen_flag,
   input wire logic       rx_push_valid,
   input wire logic [7:0] rx_push_data,
   input wire logic       rx_push_is_status,
   input wire logic       rx_exception_req
);
   // -----------------------------------------------------------------
   // received flow codes as the block should recognise them
   // -----------------------------------------------------------------
   wire logic hit_any = rx_valid && special_char_detect_en && tx_auto_inband_en
                        && (!rx_error || match_on_error_en);
   wire logic hit_stop = hit_any && rx_data == stop_char_reg;                // stop wins ties
   wire logic hit_res  = hit_any && rx_data == resume_char_reg && !hit_stop;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_SEND_RESUME: assert property (cmd_send_resume && !rx_valid
      |=> rx_resume_sent_flag && !rx_stop_sent_flag) else $error("resume send flags wrong");
   AST_SEND_STOP: assert property (cmd_send_stop && !cmd_send_resume
      |=> rx_stop_sent_flag && !rx_resume_sent_flag) else $error("stop send flags wrong");
   AST_RX_CODE: assert property (!(rx_stop_sent_flag && rx_resume_sent_flag))
      else $error("receive flow status unused code");
   AST_TX_CODE: assert property (!(tx_stopped_flag && tx_resume_seen_flag))
      else $error("transmit flow status unused code");
   AST_TX_ENABLE: assert property (cmd_tx_enable_change && !rx_valid
      |=> !tx_stopped_flag && !tx_resume_seen_flag) else $error("transmit flags not cleared");
   AST_STOP_HIT: assert property (hit_stop |=> tx_stopped_flag && !tx_resume_seen_flag)
      else $error("stop code did not halt");
   AST_RESUME_HIT: assert property (hit_res |=> !tx_stopped_flag && tx_resume_seen_flag)
      else $error("resume code not seen");
   AST_PLAIN: assert property (rx_valid && !special_char_detect_en
      |=> rx_push_valid && !rx_push_is_status && rx_push_data == $past(rx_data))
      else $error("plain character not pushed");
   AST_EXC_PAIR: assert property (rx_exception_req |-> rx_push_valid && rx_push_is_status
      ##1 rx_push_valid && !rx_push_is_status && rx_push_data == $past(rx_data, 2))
      else $error("exception pair wrong");
   cover property (rx_exception_req);
   cover property (hit_stop ##1 tx_stopped_flag);
   cover property ($fell(tx_resume_seen_flag));
endmodule : ifc_inband_flow_monitor

// file: tb_inband_flow_control.sv
`timescale 1ns/10ps
module tb_inband_flow_control;
   logic       clk_sys = 1'h0, rst = 1'h1, resume_char_wr = 1'h0, stop_char_wr = 1'h0;
   logic       special_char_detect_en = 1'h0, tx_auto_inband_en = 1'h0;
   logic       implied_resume_en = 1'h0, flow_transparency_en = 1'h0, match_on_error_en = 1'h0;
   logic       cmd_send_resume = 1'h0, cmd_send_stop = 1'h0, prescaler_tick = 1'h0;
   logic       cmd_rx_enable_change = 1'h0, cmd_tx_enable_change = 1'h0;
   logic       txq_valid = 1'h0, txq_is_delay = 1'h0, take_en = 1'h0, send_req = 1'h0;
   logic       send_err = 1'h0, pop_seen = 1'h0, tick_en = 1'h0;
   logic [7:0] char_wr_data = 8'h00, txq_data = 8'h00, send_char = 8'h00, rc, sc;
   logic       tx_take, rx_valid, rx_error, txq_pop, tx_load_valid, tx_delay_active;
   logic       rx_push_valid, rx_push_is_status, rx_exception_req, rx_stop_sent_flag;
   logic       rx_resume_sent_flag, tx_stopped_flag, tx_resume_seen_flag;
   logic [7:0] rx_data, tx_load_data, rx_push_data, resume_char_reg, stop_char_reg;
   logic [8:0] exp_push[$], exp_load[$], txq_mem[$];  // expected pushes, loads, queue
   int         errors = 0, checks_done = 0, ticks = 0, seed = 32'hCC125D05;
   always #20 clk_sys = ~clk_sys;                      // 25 MHz system clock
   ifc_inband_flow i_ifc_inband_flow (.*);
   ifc_remote_model i_ifc_remote_model (.clk_sys, .rst, .take_en, .send_req, .send_char,
      .send_err, .tx_take, .rx_valid, .rx_data, .rx_error);
   task automatic test_done;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   // one-cycle command pulse: resume, stop, rx change, tx change
   task automatic cmd(input logic [3:0] m);
      {cmd_send_resume, cmd_send_stop, cmd_rx_enable_change, cmd_tx_enable_change} = m;
      step(1);
      {cmd_send_resume, cmd_send_stop, cmd_rx_enable_change, cmd_tx_enable_change} = 4'h0;
      step(1);
   endtask : cmd
   // mode 0 plain push, 1 status then char, 2 nothing pushed
   task automatic rxc(input logic [7:0] c, input logic e, input int mode, input logic [7:0] st);
      if (mode == 1) exp_push.push_back({1'h1, st | (e ? ifc_pkg::IFC_STAT_ERRBIT : 8'h00)});
      if (mode < 2) exp_push.push_back({1'h0, c});
      {send_req, send_char, send_err} = {1'h1, c, e};
      step(1);
      send_req = 1'h0;
      step(4);
   endtask : rxc
   task automatic add(input logic dly, input logic [7:0] v);
      txq_mem.push_back({dly, v});
      if (!dly) exp_load.push_back({1'h0, v});
   endtask : add
   task automatic flags(input logic [3:0] e);
      chk("flags", {5'h00, e}, {5'h00, rx_stop_sent_flag, rx_resume_sent_flag,
         tx_stopped_flag, tx_resume_seen_flag});
   endtask : flags
   // bounded wait until every expectation and queue entry is used up
   task automatic drain;
      for (int i = 0; i < 400 && exp_push.size() + exp_load.size() + txq_mem.size() > 0; i++)
         step(1);
      if (exp_push.size() + exp_load.size() + txq_mem.size() > 0) begin
         errors++;
         test_done();
      end else begin
         step(3);
      end
   endtask : drain
   // transmit queue head, advanced one cycle after a pop
   always @(posedge clk_sys) begin
      #1;
      if (pop_seen) begin
         void'(txq_mem.pop_front());
         pop_seen = 1'h0;
      end
      txq_valid = txq_mem.size() > 0;
      {txq_is_delay, txq_data} = txq_valid ? txq_mem[0] : 9'h000;
   end
   // watcher: each result takes the oldest note
   always @(negedge clk_sys) begin
      if (txq_pop === 1'h1) pop_seen = 1'h1;
      if (rx_push_valid === 1'h1)
         chk("rx_push", exp_push.size() ? exp_push.pop_front() : 9'h1FF, {rx_push_is_status, rx_push_data});
      if (tx_load_valid === 1'h1)
         chk("tx_load", exp_load.size() ? exp_load.pop_front() : 9'h1FF, {1'h0, tx_load_data});
   end
   // prescaler ticks, counted while a delay runs
   always begin
      step(8);
      if (tick_en && tx_delay_active === 1'h1) ticks++;
      prescaler_tick = tick_en;
      step(1);
      prescaler_tick = 1'h0;
   end
   initial begin
      step(16);
      rst = 1'h0;
      step(2);
      flags(4'h0);
      chk("resume_code", {1'h0, ifc_pkg::IFC_RESUME_RST}, {1'h0, resume_char_reg});
      chk("stop_code", {1'h0, ifc_pkg::IFC_STOP_RST}, {1'h0, stop_char_reg});
      rc = 8'($random(seed)) & 8'h7F;
      sc = rc ^ 8'h01;
      {resume_char_wr, char_wr_data} = {1'h1, rc};
      step(1);
      {resume_char_wr, stop_char_wr, char_wr_data} = {1'h0, 1'h1, sc};
      step(1);
      stop_char_wr = 1'h0;
      step(1);
      chk("resume_code", {1'h0, rc}, {1'h0, resume_char_reg});
      chk("stop_code", {1'h0, sc}, {1'h0, stop_char_reg});
      exp_load.push_back({1'h0, sc});
      cmd(4'h4);
      rxc(sc, 1'h0, 0, 8'h00);
      flags(4'h8);
      add(1'h0, 8'($random(seed)) | 8'h80);
      add(1'h0, 8'($random(seed)) | 8'h80);
      take_en = 1'h1;
      drain();
      exp_load.push_back({1'h0, rc});
      cmd(4'h8);
      flags(4'h4);
      drain();
      rxc(8'($random(seed)) | 8'h80, 1'h0, 0, 8'h00);
      flags(4'h0);
      exp_load.push_back({1'h0, sc});
      cmd(4'h4);
      cmd(4'h2);
      flags(4'h0);
      {special_char_detect_en, tx_auto_inband_en} = 2'h3;
      rxc(sc, 1'h0, 1, ifc_pkg::IFC_STAT_STOP);
      flags(4'h2);
      add(1'h0, 8'($random(seed)) | 8'h80);
      add(1'h0, 8'($random(seed)) | 8'h80);
      exp_load.push_front({1'h0, rc});
      cmd(4'h8);
      step(12);
      chk("held", 9'h002, 9'(exp_load.size()));
      rxc(rc, 1'h0, 1, ifc_pkg::IFC_STAT_RESUME);
      drain();
      flags(4'h0);
      rxc(sc, 1'h1, 0, 8'h00);
      match_on_error_en = 1'h1;
      rxc(sc, 1'h1, 1, ifc_pkg::IFC_STAT_STOP);
      flags(4'h2);
      cmd(4'h1);
      flags(4'h0);
      add(1'h0, 8'($random(seed)) | 8'h80);
      drain();
      rxc(sc, 1'h0, 1, ifc_pkg::IFC_STAT_STOP);
      implied_resume_en = 1'h1;
      rxc(8'($random(seed)) | 8'h80, 1'h0, 0, 8'h00);
      flags(4'h1);
      add(1'h0, 8'($random(seed)) | 8'h80);
      drain();
      flags(4'h0);
      flow_transparency_en = 1'h1;
      rxc(sc, 1'h0, 2, 8'h00);
      flags(4'h2);
      rxc(rc, 1'h0, 2, 8'h00);
      add(1'h0, 8'($random(seed)) | 8'h80);
      drain();
      tick_en = 1'h1;
      add(1'h1, 8'h02);
      add(1'h1, 8'h01);
      add(1'h0, 8'($random(seed)) | 8'h80);
      drain();
      chk("ticks", 9'h003, 9'(ticks));
      test_done();
   end
endmodule : tb_inband_flow_control
bind ifc_inband_flow ifc_inband_flow_monitor i_ifc_inband_flow_monitor (.*);
